// [common/dsp_macro_defines.vh]
// Constants for the multiply-accumulate macro: register map, fields, resets.
// Assumes a 32-bit word-aligned register bus in front of the macro.
`ifndef DSP_MACRO_DEFINES_VH
`define DSP_MACRO_DEFINES_VH
// Register byte offsets.
`define OFS_BYPASS 12'h000
`define OFS_MODE 12'h004
`define OFS_GROUP 12'h008
`define OFS_STATUS 12'h00C
// Bypass register fields.
`define BYP_IN 0
`define BYP_C 1
`define BYP_P1 2
`define BYP_P2 3
`define BYP_OUT 4
`define BYP_W 5
// Mode register fields.
`define MD_PRODUCT_STAGE 0
`define MD_PRE0 2
`define MD_PRE1 4
`define MD_NARROW 6
`define MD_ALU 7
`define MD_SUB 9
`define MD_USEP 10
`define MD_ACC 11
`define MD_CSHIFT 12
`define MD_OSEL 13
`define MD_W 14
// Group register fields.
`define GR_ASYNC 0
`define GR_IN 4
`define GR_PIPE 6
`define GR_OUT 8
`define GR_W 10
// Reset values.
`define RST_BYPASS 5'h00
`define RST_MODE 14'h0400
`define RST_GROUP 10'h240
// Multiplier split modes.
`define MM_TWO18 2'h0
`define MM_FOUR9 2'h1
`define MM_ONE36 2'h2
// Pre-adder modes.
`define PM_PASS 2'h0
`define PM_ADD 2'h1
`define PM_SHIFT 2'h2
`define PM_DOUBLE 2'h3
// Arithmetic unit forms.
`define AF_PXY 2'h0
`define AF_PYC 2'h1
`define AF_XYC 2'h2
`define AF_CHAIN 2'h3
`endif

// [verilog/pipe_stage.v]
// Optional pipeline register with a combinational bypass path.
// Assumes resets and enable come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module pipe_stage #(
    parameter W = 18
) (
    // Clock and resets
    input wire clk,
    input wire arst,
    input wire srst,
    // Control
    input wire ce,
    input wire bypass,
    // Data
    input wire [W-1:0] d,
    output wire [W-1:0] q,
    output wire [W-1:0] q_held
);
    reg [W-1:0] r_q;

    // Loads only when enabled; either reset clears it.
    always @(posedge clk or posedge arst) begin
        if (arst) begin
            r_q <= {W{1'b0}};
        end else if (srst) begin
            r_q <= {W{1'b0}};
        end else if (ce) begin
            r_q <= d;
        end
    end

    // Bypass takes the input straight through.
    assign q = bypass ? d : r_q;
    assign q_held = r_q;
endmodule
`default_nettype wire

// [verilog/pre_adder_unit.v]
// Pre-adder: add, subtract or shift two 18-bit operands, or two 9-bit pairs.
// Assumes operands are already staged by the caller.
`timescale 1ns/100ps
`default_nettype none
`include "dsp_macro_defines.vh"
module pre_adder_unit (
    // Operands
    input wire [17:0] x,
    input wire [17:0] y,
    // Control
    input wire sub,
    input wire [1:0] mode,
    input wire narrow,
    // Result
    output reg [17:0] sum
);
    wire [17:0] y_inv;
    wire [17:0] full;
    wire [8:0] half_lo;
    wire [8:0] half_hi;
    wire [17:0] arith;

    // Subtraction is addition of the inverted operand plus one.
    assign y_inv = sub ? ~y : y;
    assign full = x + y_inv + {17'h00000, sub};
    assign half_lo = x[8:0] + y_inv[8:0] + {8'h00, sub};
    assign half_hi = x[17:9] + y_inv[17:9] + {8'h00, sub};
    assign arith = narrow ? {half_hi, half_lo} : full;

    // Mode picks pass, add/sub, shift-through or doubled sum.
    always @* begin
        case (mode)
            `PM_PASS: sum = x;
            `PM_ADD: sum = arith;
            `PM_SHIFT: sum = y;
            `PM_DOUBLE: sum = {arith[16:0], 1'b0};
            default: sum = x;
        endcase
    end
endmodule
`default_nettype wire

// [verilog/dsp_macro.v]
// One multiply-accumulate macro: pre-adders, split multipliers, 54-bit unit.
// Assumes fabric inputs share clk; configuration is written over APB.
//
// Summary of operation
// - Macro has two pre-adders, two multipliers, one unit.
// - Cascade x passes through with one cycle delay.
// - Cascade y passes through with one cycle delay.
// - Chain output is 55 bits, sign extended.
// - Chain input feeds the arithmetic unit.
// - Four enable and reset sets, sync or async.
// - Add/subtract select per pre-adder.
// - Pre-adder takes y or reverse input, x or cascade.
// - Pre-adder inputs registered or bypassed.
// - Pre-adder works at 9 or 18 bits.
// - Pre-adder adds, subtracts and shifts.
// - Multiplier splits as 18x36, two 18x18, four 9x9.
// - Two macros combine to a 36x36 multiplier.
// - Multiplier inputs and outputs registered or bypassed.
// - Arithmetic unit 54 bits, stages registered or bypassed.
// - Unit offers four product and operand sum forms.
// - Sign inputs mark operands signed or unsigned.
// - Source selects choose x and y operand origin.
`timescale 1ns/100ps
`default_nettype none
`include "dsp_macro_defines.vh"
module dsp_macro (
    // Clock and system reset
    input wire clk,
    input wire sys_rst,
    // Enables and resets for the four register sets
    input wire [3:0] ce_in,
    input wire [3:0] rst_in,
    // Operands
    input wire [17:0] x_lane0,
    input wire [17:0] y_lane0,
    input wire [17:0] x_lane1,
    input wire [17:0] y_lane1,
    input wire [53:0] addend_wide,
    // Operand control
    input wire [1:0] x_source_sel,
    input wire [1:0] y_source_sel,
    input wire [1:0] x_signed,
    input wire [1:0] y_signed,
    input wire [1:0] pre_add_sub_sel,
    // Cascades
    input wire [17:0] cascade_x_in,
    input wire [17:0] cascade_y_in,
    input wire [17:0] reverse_shift_in,
    input wire [54:0] sum_chain_in,
    output reg [17:0] cascade_x_out,
    output reg [17:0] cascade_y_out,
    output wire [17:0] reverse_shift_out,
    output wire [54:0] sum_chain_out,
    // Result
    output wire [35:0] result_out,
    // APB register bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr
);
    reg [`BYP_W-1:0] bypass_q;
    reg [`MD_W-1:0] mode_q;
    reg [`GR_W-1:0] group_q;
    reg [31:0] rdata_d;
    reg addr_hit;
    wire wr_en;
    wire [3:0] arst_set;
    wire [3:0] srst_set;
    wire [1:0] g_in;
    wire [1:0] g_pipe;
    wire [1:0] g_out;
    wire [71:0] mul_ops;
    wire [3:0] mul_sign;
    wire [35:0] in_ops;
    wire [53:0] c_st;
    wire [35:0] raw_st;
    wire [53:0] p_st;
    wire [53:0] alu_st;
    wire [53:0] alu_held;
    wire [35:0] alu_held_unused_hi;
    wire [35:0] res_st;
    reg [53:0] prod_wide;
    reg [35:0] prod_raw;
    reg [53:0] alu_d;

    // Cascade operands reach the next macro one clock later.
    always @(posedge clk) begin
        if (sys_rst) begin
            cascade_x_out <= 18'h00000;
            cascade_y_out <= 18'h00000;
        end else begin
            cascade_x_out <= cascade_x_in;
            cascade_y_out <= cascade_y_in;
        end
    end

    // Each set resets asynchronously or synchronously as configured.
    assign arst_set = rst_in & group_q[`GR_ASYNC+3:`GR_ASYNC];
    assign srst_set = (rst_in & ~group_q[`GR_ASYNC+3:`GR_ASYNC]) | {4{sys_rst}};
    assign g_in = group_q[`GR_IN+1:`GR_IN];
    assign g_pipe = group_q[`GR_PIPE+1:`GR_PIPE];
    assign g_out = group_q[`GR_OUT+1:`GR_OUT];

    // Two lanes, each with operand select, input stage and pre-adder.
    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1) begin : lane
            wire [17:0] x_par;
            wire [17:0] y_par;
            wire [17:0] x_raw;
            wire [17:0] y_raw;
            wire [35:0] st;
            wire [17:0] pre_sum;
            assign x_par = (k == 0) ? x_lane0 : x_lane1;
            assign y_par = (k == 0) ? y_lane0 : y_lane1;
            // Operand origin follows the source selects.
            assign x_raw = x_source_sel[k] ? cascade_x_in : x_par;
            assign y_raw = y_source_sel[k] ? reverse_shift_in : y_par;
            pipe_stage #(.W(36)) u_in (
                .clk(clk),
                .arst(arst_set[g_in]),
                .srst(srst_set[g_in]),
                .ce(ce_in[g_in]),
                .bypass(bypass_q[`BYP_IN]),
                .d({x_raw, y_raw}),
                .q(st),
                .q_held()
            );
            assign in_ops[18*k+17:18*k] = st[17:0];
            pre_adder_unit u_pre (
                .x(st[35:18]),
                .y(st[17:0]),
                .sub(pre_add_sub_sel[k]),
                .mode(k == 0 ? mode_q[`MD_PRE0+1:`MD_PRE0] : mode_q[`MD_PRE1+1:`MD_PRE1]),
                .narrow(mode_q[`MD_NARROW]),
                .sum(pre_sum)
            );
            // Multiplier input stage carries operands and their signs.
            pipe_stage #(.W(38)) u_p1 (
                .clk(clk),
                .arst(arst_set[g_pipe]),
                .srst(srst_set[g_pipe]),
                .ce(ce_in[g_pipe]),
                .bypass(bypass_q[`BYP_P1]),
                .d({x_signed[k], y_signed[k], pre_sum, st[17:0]}),
                .q({mul_sign[2*k+1], mul_sign[2*k], mul_ops[36*k+35:36*k]}),
                .q_held()
            );
        end
    endgenerate

    // Backward shift path hands lane 0's y operand to the previous macro.
    assign reverse_shift_out = in_ops[17:0];

    // Signed or unsigned operands are extended by one bit.
    wire signed [18:0] mx0 = {mul_sign[1] & mul_ops[35], mul_ops[35:18]};
    wire signed [18:0] my0 = {mul_sign[0] & mul_ops[17], mul_ops[17:0]};
    wire signed [18:0] mx1 = {mul_sign[3] & mul_ops[71], mul_ops[71:54]};
    wire signed [18:0] my1 = {mul_sign[2] & mul_ops[53], mul_ops[53:36]};
    wire signed [36:0] my_wide = {mul_sign[2] & mul_ops[53], mul_ops[53:36], mul_ops[17:0]};
    wire signed [37:0] p0 = mx0 * my0;
    wire signed [37:0] p1 = mx1 * my1;
    wire signed [55:0] p_long = mx0 * my_wide;

    // Nine-bit halves of each operand, extended per their sign marks.
    wire signed [9:0] hx00 = {mul_sign[1] & mul_ops[26], mul_ops[26:18]};
    wire signed [9:0] hx01 = {mul_sign[1] & mul_ops[35], mul_ops[35:27]};
    wire signed [9:0] hy00 = {mul_sign[0] & mul_ops[8], mul_ops[8:0]};
    wire signed [9:0] hy01 = {mul_sign[0] & mul_ops[17], mul_ops[17:9]};
    wire signed [9:0] hx10 = {mul_sign[3] & mul_ops[62], mul_ops[62:54]};
    wire signed [9:0] hx11 = {mul_sign[3] & mul_ops[71], mul_ops[71:63]};
    wire signed [9:0] hy10 = {mul_sign[2] & mul_ops[44], mul_ops[44:36]};
    wire signed [9:0] hy11 = {mul_sign[2] & mul_ops[53], mul_ops[53:45]};
    wire signed [19:0] q00 = hx00 * hy00;
    wire signed [19:0] q01 = hx01 * hy01;
    wire signed [19:0] q10 = hx10 * hy10;
    wire signed [19:0] q11 = hx11 * hy11;
    wire signed [53:0] q_sum = q00 + q01 + q10 + q11;
    wire signed [53:0] p_sum = p0 + p1;

    // Split mode picks the product fed on and the raw product shown.
    always @* begin
        case (mode_q[`MD_PRODUCT_STAGE+1:`MD_PRODUCT_STAGE])
            `MM_TWO18: begin
                prod_wide = p_sum;
                prod_raw = p0[35:0];
            end
            `MM_FOUR9: begin
                prod_wide = q_sum;
                prod_raw = {q01[17:0], q00[17:0]};
            end
            `MM_ONE36: begin
                prod_wide = p_long[53:0];
                prod_raw = p_long[35:0];
            end
            default: begin
                prod_wide = p_sum;
                prod_raw = p0[35:0];
            end
        endcase
    end

    // Product stage output register.
    pipe_stage #(.W(90)) u_p2 (
        .clk(clk),
        .arst(arst_set[g_pipe]),
        .srst(srst_set[g_pipe]),
        .ce(ce_in[g_pipe]),
        .bypass(bypass_q[`BYP_P2]),
        .d({prod_raw, prod_wide}),
        .q({raw_st, p_st}),
        .q_held()
    );

    // Wide addend input register.
    pipe_stage #(.W(54)) u_c (
        .clk(clk),
        .arst(arst_set[g_in]),
        .srst(srst_set[g_in]),
        .ce(ce_in[g_in]),
        .bypass(bypass_q[`BYP_C]),
        .d(addend_wide),
        .q(c_st),
        .q_held()
    );

    // Concatenated lane operands, extended by their sign marks.
    wire [53:0] a_op = {{18{mul_sign[3] & mul_ops[71]}}, mul_ops[71:54], mul_ops[35:18]};
    wire [53:0] b_op = {{18{mul_sign[2] & mul_ops[53]}}, mul_ops[53:36], mul_ops[17:0]};
    wire [53:0] p_use = mode_q[`MD_USEP] ? p_st : 54'h00000000000000;
    wire [53:0] c_use = mode_q[`MD_ACC] ? alu_held : c_st;
    // A shifted chain lets the upper macro finish a 36x36 product.
    wire [53:0] chain_arg = mode_q[`MD_CSHIFT] ? {{18{sum_chain_in[54]}}, sum_chain_in[53:18]}
                                               : sum_chain_in[53:0];
    wire alu_sub = mode_q[`MD_SUB];

    // Three-input arithmetic in the configured form.
    always @* begin
        case (mode_q[`MD_ALU+1:`MD_ALU])
            `AF_PXY: alu_d = alu_sub ? p_use + a_op - b_op : p_use + a_op + b_op;
            `AF_PYC: alu_d = alu_sub ? p_use + b_op - c_use : p_use + b_op + c_use;
            `AF_XYC: alu_d = alu_sub ? a_op + b_op - c_use : a_op + b_op + c_use;
            `AF_CHAIN: alu_d = alu_sub ? p_use + c_use - chain_arg : p_use + c_use + chain_arg;
            default: alu_d = p_use;
        endcase
    end

    // Output register for the unit and the result bus.
    pipe_stage #(.W(90)) u_out (
        .clk(clk),
        .arst(arst_set[g_out]),
        .srst(srst_set[g_out]),
        .ce(ce_in[g_out]),
        .bypass(bypass_q[`BYP_OUT]),
        .d({mode_q[`MD_OSEL] ? raw_st : alu_d[35:0], alu_d}),
        .q({res_st, alu_st}),
        .q_held({alu_held_unused_hi, alu_held})
    );

    assign result_out = res_st;
    assign sum_chain_out = {alu_st[53], alu_st};

    // APB: zero wait states; read data captured in the setup cycle.
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;
    assign wr_en = psel & penable & pwrite & addr_hit;

    // Address decode and read mux.
    always @* begin
        addr_hit = 1'b1;
        rdata_d = 32'h00000000;
        case (paddr)
            `OFS_BYPASS: rdata_d = {27'h0000000, bypass_q};
            `OFS_MODE: rdata_d = {18'h00000, mode_q};
            `OFS_GROUP: rdata_d = {22'h000000, group_q};
            `OFS_STATUS: rdata_d = result_out[31:0];
            default: addr_hit = 1'b0;
        endcase
    end

    // Configuration registers and read data register.
    always @(posedge clk) begin
        if (sys_rst) begin
            bypass_q <= `RST_BYPASS;
            mode_q <= `RST_MODE;
            group_q <= `RST_GROUP;
            prdata <= 32'h00000000;
        end else begin
            if (psel & ~penable) begin
                prdata <= rdata_d;
            end
            if (wr_en && paddr == `OFS_BYPASS) begin
                bypass_q <= pwdata[`BYP_W-1:0];
            end
            if (wr_en && paddr == `OFS_MODE) begin
                mode_q <= pwdata[`MD_W-1:0];
            end
            if (wr_en && paddr == `OFS_GROUP) begin
                group_q <= pwdata[`GR_W-1:0];
            end
        end
    end
endmodule
`default_nettype wire

// [sim/upstream_block.sv]
// Model of the neighbouring block that feeds the macro's cascade inputs.
// Assumes one clock and a synchronous active-high reset shared with the macro.
`timescale 1ns/100ps
`default_nettype none
module upstream_block (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Values the fabric hands to the neighbour
    input wire logic [17:0] seed_x,
    input wire logic [17:0] seed_y,
    input wire logic [17:0] seed_rev,
    input wire logic [53:0] seed_sum,
    // Registered cascade outputs toward the macro
    output logic [17:0] x_out_q,
    output logic [17:0] y_out_q,
    output logic [17:0] rev_out_q,
    output logic [54:0] sum_out_q
);
    // The neighbour registers what it sends, one cycle late like a real block.
    always @(posedge clk) begin
        if (sys_rst) begin
            x_out_q <= 18'h00000;
            y_out_q <= 18'h00000;
            rev_out_q <= 18'h00000;
            sum_out_q <= 55'h0;
        end else begin
            x_out_q <= seed_x;
            y_out_q <= seed_y;
            rev_out_q <= seed_rev;
            sum_out_q <= {seed_sum[53], seed_sum};
        end
    end
endmodule
`default_nettype wire

// [sim/dsp_macro_monitor.sv]
// Port checker for the multiply-accumulate macro.
// Assumes it is bound to every macro instance and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module dsp_macro_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Cascades and results
    input wire logic [17:0] cascade_x_in,
    input wire logic [17:0] cascade_y_in,
    input wire logic [17:0] cascade_x_out,
    input wire logic [17:0] cascade_y_out,
    input wire logic [54:0] sum_chain_out,
    input wire logic [35:0] result_out,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Only the four aligned words at the bottom of the map are decoded.
    logic mapped;
    assign mapped = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
    // Setup of a status read, then the access phase that follows it.
    sequence status_setup;
        psel && !penable && !pwrite && (paddr == 12'h00C);
    endsequence
    sequence bus_access;
        psel && penable;
    endsequence
    casc_x_delay_a: assert property (
        !$past(sys_rst) |-> cascade_x_out == $past(cascade_x_in))
        else $error("cascade x output is not the input of one cycle before");
    casc_y_delay_a: assert property (
        !$past(sys_rst) |-> cascade_y_out == $past(cascade_y_in))
        else $error("cascade y output is not the input of one cycle before");
    chain_sign_a: assert property (
        sum_chain_out[54] == sum_chain_out[53])
        else $error("chain output top bit is not a sign extension");
    status_read_a: assert property (
        status_setup ##1 bus_access |-> prdata == $past(result_out[31:0]))
        else $error("status read does not return the result bus");
    ready_high_a: assert property (pready)
        else $error("bus ready dropped");
    unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    err_phase_a: assert property (pslverr |-> psel && penable && !mapped)
        else $error("error flag outside an unmapped access");
    unmapped_zero_a: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read is not zero");
    reset_clear_a: assert property (
        $past(sys_rst) |-> result_out == 36'h0 && sum_chain_out == 55'h0 && cascade_x_out == 18'h0)
        else $error("outputs not cleared by reset");
endmodule
bind dsp_macro dsp_macro_monitor mon (.clk(clk), .sys_rst(sys_rst),
    .cascade_x_in(cascade_x_in), .cascade_y_in(cascade_y_in),
    .cascade_x_out(cascade_x_out), .cascade_y_out(cascade_y_out),
    .sum_chain_out(sum_chain_out), .result_out(result_out), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
`default_nettype wire

// [sim/dsp_multiply_accumulate_macro_tb_top.sv]
// Self-checking bench for the multiply-accumulate macro.
// Assumes the neighbour model and the bound port checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module dsp_multiply_accumulate_macro_tb_top;
    logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [3:0] ce_in = 4'hF, rst_in = 4'h0;
    logic [17:0] x_lane0 = 18'h0, y_lane0 = 18'h0, x_lane1 = 18'h0, y_lane1 = 18'h0;
    logic [17:0] seed_x = 18'h0, seed_y = 18'h0, seed_rev = 18'h0;
    logic [53:0] addend_wide = 54'h0, seed_sum = 54'h0;
    logic [1:0] x_source_sel = 2'h0, y_source_sel = 2'h0, x_signed = 2'h0, y_signed = 2'h0;
    logic [1:0] pre_add_sub_sel = 2'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [17:0] cascade_x_in, cascade_y_in, reverse_shift_in, cascade_x_out, cascade_y_out;
    logic [54:0] sum_chain_in, sum_chain_out;
    logic [35:0] result_out;
    logic [17:0] rev_out;
    logic pready, pslverr, err;
    int error_cnt = 0, n_compared = 0;
    // Half-period toggle gives 125 MHz.
    always #4 clk = ~clk;
    upstream_block nbr (.clk(clk), .sys_rst(sys_rst), .seed_x(seed_x), .seed_y(seed_y),
        .seed_rev(seed_rev), .seed_sum(seed_sum), .x_out_q(cascade_x_in),
        .y_out_q(cascade_y_in), .rev_out_q(reverse_shift_in), .sum_out_q(sum_chain_in));
    dsp_macro dut (.clk(clk), .sys_rst(sys_rst), .ce_in(ce_in), .rst_in(rst_in),
        .x_lane0(x_lane0), .y_lane0(y_lane0), .x_lane1(x_lane1), .y_lane1(y_lane1),
        .addend_wide(addend_wide), .x_source_sel(x_source_sel), .y_source_sel(y_source_sel),
        .x_signed(x_signed), .y_signed(y_signed), .pre_add_sub_sel(pre_add_sub_sel),
        .cascade_x_in(cascade_x_in), .cascade_y_in(cascade_y_in),
        .reverse_shift_in(reverse_shift_in), .sum_chain_in(sum_chain_in),
        .cascade_x_out(cascade_x_out), .cascade_y_out(cascade_y_out),
        .reverse_shift_out(rev_out), .sum_chain_out(sum_chain_out), .result_out(result_out),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Compares one value and counts the outcome.
    task check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task stop_test;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One bus transfer; holds the request until ready is seen at an edge.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reset values, read-back and an unmapped word.
    task t_regs;
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h400);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h240);
        apb(1'b0, 12'h010, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        apb(1'b1, 12'h004, 32'h2400);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h2400);
    endtask
    // A changing pattern walks through the neighbour and out of the macro.
    task t_cascade;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            seed_x <= 18'h12345 + 18'(i) * 18'h01111;
            seed_y <= ~(18'h12345 + 18'(i) * 18'h01111);
            @(negedge clk);
            if (i >= 2) begin
                check(cascade_x_out, 18'h12345 + 18'(i - 2) * 18'h01111);
                check(cascade_y_out, 18'(~(18'h12345 + 18'(i - 2) * 18'h01111)));
            end
        end
    endtask
    // Raw lane 0 product with every stage bypassed.
    task t_product_stage(input logic [17:0] x, input logic [17:0] y, input logic xs, input logic ys,
        input logic xsel, input logic ysel);
        logic signed [36:0] p;
        p = $signed({xs & x[17], x}) * $signed({ys & y[17], y});
        @(posedge clk);
        seed_x <= x;
        seed_rev <= y;
        x_lane0 <= xsel ? ~x : x;
        y_lane0 <= ysel ? ~y : y;
        x_signed <= {1'b0, xs};
        y_signed <= {1'b0, ys};
        x_source_sel <= {1'b0, xsel};
        y_source_sel <= {1'b0, ysel};
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(result_out, p[35:0]);
    endtask
    // Pre-adder sum or difference times y, plus y and plus or minus the addend, or plus the addend and the chain.
    task t_arith(input logic [31:0] md, input logic [1:0] sub, input logic [35:0] exp);
        apb(1'b1, 12'h004, md);
        @(posedge clk);
        x_lane0 <= 18'h00005;
        y_lane0 <= 18'h00003;
        addend_wide <= 54'h100;
        seed_sum <= 54'h1000;
        pre_add_sub_sel <= sub;
        x_source_sel <= 2'h0;
        y_source_sel <= 2'h0;
        x_signed <= 2'h0;
        y_signed <= 2'h0;
        @(posedge clk);
        @(negedge clk);
        check(result_out, exp);
        check(sum_chain_out, {{19{exp[35]}}, exp});
        check(rev_out, 18'h00003);
    endtask
    // Four registered stages, enable hold, status read and both reset kinds.
    task t_pipe;
        @(posedge clk);
        x_lane0 <= 18'h00000;
        y_lane0 <= 18'h00000;
        x_source_sel <= 2'h0;
        y_source_sel <= 2'h0;
        x_signed <= 2'h0;
        y_signed <= 2'h0;
        apb(1'b1, 12'h004, 32'h2400);
        apb(1'b1, 12'h000, 32'h0);
        @(posedge clk);
        x_lane0 <= 18'h00007;
        y_lane0 <= 18'h00009;
        for (int k = 1; k <= 4; k++) begin
            @(posedge clk);
            @(negedge clk);
            check(result_out, (k < 4) ? 36'h0 : 36'h3F);
        end
        @(posedge clk);
        ce_in <= 4'h0;
        x_lane0 <= 18'h00002;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check(result_out, 36'h3F);
        apb(1'b0, 12'h00C, 32'h0);
        check(rd, 32'h3F);
        @(posedge clk);
        ce_in <= 4'hF;
        rst_in <= 4'h4;
        @(posedge clk);
        rst_in <= 4'h0;
        @(negedge clk);
        check(result_out, 36'h0);
        apb(1'b1, 12'h008, 32'h244);
        @(negedge clk);
        check(result_out, 36'h12);
        @(posedge clk);
        rst_in <= 4'h4;
        @(negedge clk);
        check(result_out, 36'h0);
        @(posedge clk);
        rst_in <= 4'h0;
    endtask
    // Main sequence.
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_cascade();
        apb(1'b1, 12'h000, 32'h1F);
        t_product_stage(18'h00003, 18'h00005, 1'b0, 1'b0, 1'b0, 1'b0);
        t_product_stage(18'h3FFFF, 18'h00002, 1'b1, 1'b0, 1'b0, 1'b0);
        t_product_stage(18'h3FFFF, 18'h3FFFF, 1'b0, 1'b0, 1'b1, 1'b1);
        t_product_stage(18'h3FFFE, 18'h3FFFD, 1'b1, 1'b1, 1'b0, 1'b1);
        t_product_stage(18'h00011, 18'h20000, 1'b0, 1'b1, 1'b1, 1'b0);
        t_arith(32'h484, 2'h0, 36'h11B);
        t_arith(32'h484, 2'h1, 36'h109);
        t_arith(32'h684, 2'h0, 36'hFFFFFFF1B);
        t_arith(32'h584, 2'h0, 36'h1118);
        t_pipe();
        stop_test();
    end
    // Cuts a hang short well after the expected run length.
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
